/* File: hdl/fspc_consts.svh */
// Constants of the flash self-programming controller: offsets, fields, reset values, timing.
// Assumes inclusion by bare name from the package and the controller module.
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// ********************
// Register offsets
// ********************
`define FSPC_OFS_CTRL 12'h000
`define FSPC_OFS_ADDR 12'h004
`define FSPC_OFS_DATA 12'h008
`define FSPC_OFS_STAT 12'h00C
`define FSPC_OFS_CMD 12'h010
`define FSPC_OFS_LOCK 12'h014
`define FSPC_OFS_RDAT 12'h018
`define FSPC_OFS_VEC 12'h01C

// ********************
// Control register fields and command patterns (low five bits)
// ********************
`define FSPC_BIT_STORE 0
`define FSPC_BIT_LOCKSET 3
`define FSPC_BIT_REEN 4
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_IE 7
`define FSPC_PAT_LOAD 5'h01
`define FSPC_PAT_ERASE 5'h03
`define FSPC_PAT_WRITE 5'h05
`define FSPC_PAT_LOCK 5'h09
`define FSPC_PAT_REEN 5'h11
`define FSPC_PAT_MASK 5'h1F

// ********************
// Lock fields, reset values, vectors
// ********************
`define FSPC_LOCK_LSB 2
`define FSPC_LOCK_MSB 5
`define FSPC_LOCK_RESET 4'hF
`define FSPC_BOOT_WP_BIT 2
`define FSPC_APP_WP_BIT 0
`define FSPC_APP_VECTOR 16'h0000
`define FSPC_OK 2'h0
`define FSPC_SLVERR 2'h2

// ********************
// Timing
// ********************
`define FSPC_WINDOW_CYC 3'h4
`define FSPC_CLK_MHZ 100
`define FSPC_PROG_US 3700
`define FSPC_PROG_CYC (`FSPC_PROG_US * `FSPC_CLK_MHZ)

`endif

/* File: hdl/fspc_pkg.sv */
// Types of the flash self-programming controller.
// Assumes the constants header sits beside it.
`include "fspc_consts.svh"

package fspc_pkg;
	typedef enum logic [1:0] {FSPC_OP_NONE, FSPC_OP_ERASE, FSPC_OP_WRITE, FSPC_OP_LOCK} fspc_op_t;
	typedef enum {FSPC_IDLE, FSPC_ARMED, FSPC_BUSY} fspc_state_t;
	typedef struct packed {
		logic busy;
		logic stall;
		logic rww_block;
		logic irq;
	} fspc_status_t;
endpackage : fspc_pkg

/* File: hdl/fspc_ctrl.sv */
// Flash self-programming controller: timed command window, page buffer, erase/write/lock.
// Assumes an AXI4-Lite master, a boot vector fuse pin and an EEPROM busy level from outside.
//
// What this block does
// - Reset vector follows boot vector fuse.
// - Processor never writes any fuse.
// - Latch target address at operation start.
// - Lock setting ignores the address pointer.
// - Reads page buffer bytes via pointer bit 0.
// - Erase pattern plus store within four cycles.
// - Halting-section program stalls the processor.
// - Load pattern stores data at word offset.
// - Page buffer clears on write, reenable, reset.
// - EEPROM write during loading discards buffer.
// - Write pattern programs page, data ignored.
// - Interrupt asserted while store bit clear.
// - Busy flag set while concurrent section blocked.
// - Lock pattern programs zero data bits 5:2.
// - EEPROM write refuses programming and lock reads.
// - Whole flash readable during lock programming.
// - Store and lock bits clear at operation end, or after four cycles without a store.
// - Boot lock bits forbid boot-section writes.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_consts.svh"

module fspc_ctrl #(
	parameter int PAGE_WORDS = 32,
	parameter int ADDR_W = 16,
	parameter int PROG_CYCLES = `FSPC_PROG_CYC,
	parameter logic [15:0] BOOT_START = 16'h0C00,
	parameter logic [15:0] HALT_START = 16'h0C00
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and core
	input wire logic boot_vector_fuse,
	input wire logic eeprom_write_busy,
	// Outputs
	output logic [15:0] reset_vector,
	output var fspc_pkg::fspc_status_t status,
	output logic [7:0] flash_op_page_buf
);
	localparam int WB = $clog2(PAGE_WORDS);

	// ********************
	// Pin synchronisers
	// ********************
	logic fuse_m, fuse_s, ee_m, ee_s;
	always_ff @(posedge aclk) begin
		fuse_m <= boot_vector_fuse;
		fuse_s <= fuse_m;
		ee_m <= eeprom_write_busy;
		ee_s <= ee_m;
	end

	// ********************
	// Software state
	// ********************
	logic [ADDR_W-1:0] ptr;
	logic [15:0] data_pair;
	logic [7:0] ctrl;
	logic ie;
	logic [3:0] lockbits;
	logic [15:0] page_buf [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] buf_valid;
	logic [ADDR_W-1:0] op_addr;
	fspc_pkg::fspc_op_t op;
	fspc_pkg::fspc_state_t state;
	logic [2:0] win;
	logic [31:0] prog_cnt;
	logic rww_busy;
	logic [7:0] rdat;

	// ********************
	// Bus decode
	// ********************
	logic aw_have, w_have;
	logic [11:0] aw_q;
	logic [31:0] w_q;
	wire do_wr = aw_have && w_have && !s_axi_bvalid;
	wire wr_ctrl = do_wr && aw_q == `FSPC_OFS_CTRL;
	wire wr_addr = do_wr && aw_q == `FSPC_OFS_ADDR;
	wire wr_data = do_wr && aw_q == `FSPC_OFS_DATA;
	wire wr_cmd = do_wr && aw_q == `FSPC_OFS_CMD;
	wire wr_rd = do_wr && aw_q == `FSPC_OFS_RDAT;
	wire wr_map = wr_ctrl || wr_addr || wr_data || wr_cmd || wr_rd;
	wire [4:0] pat = w_q[4:0] & `FSPC_PAT_MASK;
	// EEPROM writes lock software out of every programming command.
	wire cmd_ok = wr_ctrl && state == fspc_pkg::FSPC_IDLE && !ee_s;
	wire known = pat == `FSPC_PAT_LOAD || pat == `FSPC_PAT_ERASE ||
		pat == `FSPC_PAT_WRITE || pat == `FSPC_PAT_LOCK;
	wire reen = cmd_ok && pat == `FSPC_PAT_REEN;
	wire store = wr_cmd && state == fspc_pkg::FSPC_ARMED && !ee_s;
	wire [4:0] cpat = ctrl[4:0];
	wire in_boot = ptr >= BOOT_START;
	wire in_halt = ptr >= HALT_START;
	// Boot or application write protection from programmed lock bits.
	wire wp = in_boot ? !lockbits[`FSPC_BOOT_WP_BIT] : !lockbits[`FSPC_APP_WP_BIT];
	wire [WB-1:0] widx = ptr[WB:1];
	wire pg_write = store && cpat == `FSPC_PAT_WRITE && !wp;
	wire pg_erase = store && cpat == `FSPC_PAT_ERASE && !wp;
	wire lock_set = store && cpat == `FSPC_PAT_LOCK;
	wire op_start = pg_erase || pg_write || lock_set;
	wire done = state == fspc_pkg::FSPC_BUSY && prog_cnt == 32'h0;
	wire clr_buf = (done && op == fspc_pkg::FSPC_OP_WRITE) || reen ||
		(ee_s && |buf_valid);

	// ********************
	// Write channel capture
	// ********************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= 12'h000;
			w_q <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FSPC_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_q <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `FSPC_OK : `FSPC_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_have;
	assign s_axi_wready = !w_have;

	// ********************
	// Command sequencer
	// ********************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fspc_pkg::FSPC_IDLE;
			ctrl <= 8'h00;
			ie <= 1'b0;
			win <= 3'h0;
			op <= fspc_pkg::FSPC_OP_NONE;
			op_addr <= '0;
			prog_cnt <= 32'h0;
			rww_busy <= 1'b0;
			lockbits <= `FSPC_LOCK_RESET;
			ptr <= '0;
			data_pair <= 16'h0000;
		end else begin
			if (wr_addr) ptr <= w_q[ADDR_W-1:0];
			if (wr_data) data_pair <= w_q[15:0];
			if (wr_ctrl) ie <= w_q[`FSPC_BIT_IE];
			if (reen) rww_busy <= 1'b0;
			unique case (state)
				fspc_pkg::FSPC_IDLE: begin
					if (cmd_ok && known) begin
						ctrl <= {3'h0, pat};
						win <= `FSPC_WINDOW_CYC;
						state <= fspc_pkg::FSPC_ARMED;
					end
				end
				fspc_pkg::FSPC_ARMED: begin
					if (store) begin
						if (pg_erase || pg_write || lock_set) begin
							state <= fspc_pkg::FSPC_BUSY;
							prog_cnt <= PROG_CYCLES - 1;
							op_addr <= ptr;
							op <= pg_erase ? fspc_pkg::FSPC_OP_ERASE :
								pg_write ? fspc_pkg::FSPC_OP_WRITE : fspc_pkg::FSPC_OP_LOCK;
							// Lock setting never touches the pointer.
							if (lock_set) lockbits <= lockbits &
								data_pair[`FSPC_LOCK_MSB:`FSPC_LOCK_LSB];
							else rww_busy <= 1'b1;
						end else begin
							ctrl <= 8'h00;
							state <= fspc_pkg::FSPC_IDLE;
						end
					end else if (win == 3'h1) begin
						ctrl <= 8'h00;
						state <= fspc_pkg::FSPC_IDLE;
					end else begin
						win <= win - 3'h1;
					end
				end
				fspc_pkg::FSPC_BUSY: begin
					if (done) begin
						ctrl <= 8'h00;
						op <= fspc_pkg::FSPC_OP_NONE;
						state <= fspc_pkg::FSPC_IDLE;
					end else begin
						prog_cnt <= prog_cnt - 32'h1;
					end
				end
			endcase
		end
	end

	// ********************
	// Temporary page buffer
	// ********************
	wire ld = store && cpat == `FSPC_PAT_LOAD;
	genvar g;
	generate
		for (g = 0; g < PAGE_WORDS; g++) begin : gen_buf
			always_ff @(posedge aclk) begin
				if (!aresetn || clr_buf) begin
					buf_valid[g] <= 1'b0;
					page_buf[g] <= 16'hFFFF;
				end else if (ld && widx == WB'(g) && !buf_valid[g]) begin
					buf_valid[g] <= 1'b1;
					page_buf[g] <= data_pair;
				end
			end
		end
	endgenerate

	// ********************
	// Read channel and outputs
	// ********************
	wire [15:0] rword = page_buf[widx];
	wire [7:0] rbyte = ptr[0] ? rword[15:8] : rword[7:0];
	wire [7:0] lock_byte = {2'h3, lockbits, 2'h3};
	wire [7:0] stat_byte = {ie, rww_busy, 1'b0, ctrl[4:0]};
	logic [31:0] rmux;
	logic rhit;
	always_comb begin
		rhit = 1'b1;
		unique case (s_axi_araddr)
			`FSPC_OFS_CTRL: rmux = {24'h0, stat_byte};
			`FSPC_OFS_ADDR: rmux = 32'(ptr);
			`FSPC_OFS_DATA: rmux = {16'h0, data_pair};
			`FSPC_OFS_STAT: rmux = {28'h0, status};
			`FSPC_OFS_CMD: rmux = 32'h0;
			// Lock read-back is refused during EEPROM writes.
			`FSPC_OFS_LOCK: rmux = ee_s ? 32'h0 : {24'h0, lock_byte};
			`FSPC_OFS_RDAT: rmux = {24'h0, rdat};
			`FSPC_OFS_VEC: rmux = {16'h0, reset_vector};
			default: begin
				rmux = 32'h0;
				rhit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `FSPC_OK;
			rdat <= 8'h00;
			reset_vector <= `FSPC_APP_VECTOR;
			status <= '0;
			flash_op_page_buf <= 8'h00;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rmux;
				s_axi_rresp <= rhit ? `FSPC_OK : `FSPC_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (wr_rd) rdat <= rbyte;
			// The fuse is only ever sampled; no path writes it.
			reset_vector <= fuse_s ? `FSPC_APP_VECTOR : BOOT_START;
			// Busy and stall rise with the accepted store, in step with the block flag.
			status.busy <= (state == fspc_pkg::FSPC_BUSY && !done) || op_start;
			// Locking keeps the whole array readable, so no stall or block.
			status.stall <= (state == fspc_pkg::FSPC_BUSY && !done &&
				op != fspc_pkg::FSPC_OP_LOCK && op_addr >= HALT_START) ||
				((pg_erase || pg_write) && in_halt);
			status.rww_block <= (rww_busy || pg_erase || pg_write) && !reen;
			status.irq <= ie && !(ctrl[`FSPC_BIT_STORE] && !done);
			flash_op_page_buf <= {6'h0, in_halt, |buf_valid};
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
endmodule : fspc_ctrl
`default_nettype wire

/* File: verif/fspc_monitor.sv */
// Checker of the self-programming controller outputs.
// Bound onto fspc_ctrl; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module fspc_monitor #(
	parameter int PROG_CYCLES = 20,
	parameter logic [15:0] BOOT_START = 16'h0C00
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Watched ports
	input wire logic boot_vector_fuse,
	input wire logic eeprom_write_busy,
	input wire logic [15:0] reset_vector,
	input wire fspc_pkg::fspc_status_t status
);
	// ****
	// Properties
	// ****
	// The margin covers the start edge and the pin synchronisers.
	localparam int BUSY_MAX = PROG_CYCLES + 8;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_op_start;
		$rose(status.busy);
	endsequence
	sequence s_ee_held;
		eeprom_write_busy [*4];
	endsequence
	property p_vec_app;
		boot_vector_fuse [*5] |-> reset_vector == 16'h0000;
	endproperty
	a_vec_app: assert property (p_vec_app) else $error("vector not app");
	property p_vec_boot;
		!boot_vector_fuse [*5] |-> reset_vector == BOOT_START;
	endproperty
	a_vec_boot: assert property (p_vec_boot) else $error("vector not boot");
	property p_irq_idle;
		status.irq |-> !status.busy;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq while busy");
	property p_stall_op;
		status.stall |-> status.busy;
	endproperty
	a_stall_op: assert property (p_stall_op) else $error("stall while idle");
	property p_blk_op;
		$rose(status.rww_block) |-> status.busy;
	endproperty
	a_blk_op: assert property (p_blk_op) else $error("block without op");
	property p_op_min;
		s_op_start |-> status.busy [*8];
	endproperty
	a_op_min: assert property (p_op_min) else $error("op too short");
	property p_op_max;
		s_op_start |-> ##[1:BUSY_MAX] !status.busy;
	endproperty
	a_op_max: assert property (p_op_max) else $error("op too long");
	property p_ee_refuse;
		s_ee_held |-> !$rose(status.busy);
	endproperty
	a_ee_refuse: assert property (p_ee_refuse) else $error("op during eeprom");
endmodule : fspc_monitor
bind fspc_ctrl fspc_monitor #(.PROG_CYCLES(PROG_CYCLES), .BOOT_START(BOOT_START)) u_monitor (
	.aclk(aclk),
	.aresetn(aresetn),
	.boot_vector_fuse(boot_vector_fuse),
	.eeprom_write_busy(eeprom_write_busy),
	.reset_vector(reset_vector),
	.status(status)
);
`default_nettype wire

/* File: verif/fspc_ee_model.sv */
// EEPROM writer beside the controller: holds its busy level a while.
// Assumes a one-cycle go pulse from the bench.
`timescale 1ns/1ns
`default_nettype none
module fspc_ee_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control and level
	input wire logic go,
	output logic eeprom_write_busy
);
	int cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt <= 0;
		else if (go) cnt <= 30;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	assign eeprom_write_busy = cnt > 0;
endmodule : fspc_ee_model
`default_nettype wire

/* File: verif/flash_self_program_controller_bench.sv */
// Self-checking bench of the controller over AXI4-Lite.
// Assumes the design, its constants header and the EEPROM model.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_consts.svh"
module flash_self_program_controller_bench;
	logic aclk = 0, aresetn = 0, boot_vector_fuse = 1, ee_go = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, ld_v;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic eeprom_write_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] reset_vector;
	logic [7:0] flash_op_page_buf;
	fspc_pkg::fspc_status_t status;
	int fail_count = 0, cmp_count = 0, cyc = 0, lock_m = 15, nib;
	int pats[$] = '{3, 5, 9};
	always #5 aclk = ~aclk;
	fspc_ctrl #(.PROG_CYCLES(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1),
		.boot_vector_fuse, .eeprom_write_busy, .reset_vector, .status, .flash_op_page_buf);
	fspc_ee_model i_ee (.aclk, .aresetn, .go(ee_go), .eeprom_write_busy);
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task automatic cmd(input logic [31:0] p);
		wr(`FSPC_OFS_CTRL, p);
		wr(`FSPC_OFS_CMD, 32'h0);
	endtask : cmd
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// The whole run needs well under a thousand cycles.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		nib = $urandom(4577);
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (6) @(posedge aclk);
		chk(reset_vector, 32'h0);
		boot_vector_fuse <= 1'h0;
		repeat (6) @(posedge aclk);
		rd(`FSPC_OFS_VEC);
		chk(d[15:0], 32'h0C00);
		boot_vector_fuse <= 1'h1;
		rd(12'hFC);
		chk(r, `FSPC_SLVERR);
		$display("test vector done");
		wr(`FSPC_OFS_ADDR, 32'hC40);
		cmd(32'h3);
		@(posedge aclk);
		chk(status.stall, 32'h1);
		chk(flash_op_page_buf[1], 32'h1);
		wr(`FSPC_OFS_ADDR, 32'h40);
		chk(status.stall, 32'h1);
		repeat (25) @(posedge aclk);
		chk(status.stall, 32'h0);
		wr(`FSPC_OFS_CTRL, 32'h11);
		$display("test stall done");
		foreach (pats[i]) begin
			nib = $urandom & 15;
			wr(`FSPC_OFS_ADDR, 32'h40);
			wr(`FSPC_OFS_DATA, 32'hC3 | (nib << 2));
			if (pats[i] == 9) wr(`FSPC_OFS_ADDR, 32'h1);
			cmd(pats[i] | 32'h80);
			rd(`FSPC_OFS_CTRL);
			chk(d[0], 32'h1);
			chk(status.stall, 32'h0);
			repeat (60) begin
				rd(`FSPC_OFS_CTRL);
				if (d[0] === 1'h0) break;
			end
			chk(d[6], pats[i] != 9);
			chk(status.irq, 32'h1);
			chk(status.rww_block, pats[i] != 9);
			if (pats[i] == 9) lock_m &= nib;
			rd(`FSPC_OFS_LOCK);
			chk(d[5:2], lock_m);
			wr(`FSPC_OFS_CTRL, 32'h11);
			rd(`FSPC_OFS_STAT);
			chk(d[1], 32'h0);
			chk(status.rww_block, 32'h0);
			$display("test op %0d done", pats[i]);
		end
		wr(`FSPC_OFS_CTRL, 32'h1);
		repeat (6) @(posedge aclk);
		wr(`FSPC_OFS_CMD, 32'h0);
		cmd(32'h7);
		rd(`FSPC_OFS_CTRL);
		chk(d[0], 32'h0);
		chk(status.busy, 32'h0);
		chk(flash_op_page_buf[0], 32'h0);
		ld_v = $urandom;
		wr(`FSPC_OFS_ADDR, 32'h40);
		wr(`FSPC_OFS_DATA, ld_v);
		cmd(32'h1);
		repeat (2) @(posedge aclk);
		chk(flash_op_page_buf[0], 32'h1);
		wr(`FSPC_OFS_RDAT, 32'h0);
		rd(`FSPC_OFS_RDAT);
		chk(d[7:0], ld_v[7:0]);
		wr(`FSPC_OFS_ADDR, 32'h41);
		wr(`FSPC_OFS_RDAT, 32'h0);
		rd(`FSPC_OFS_RDAT);
		chk(d[7:0], ld_v[15:8]);
		ee_go <= 1'h1;
		@(posedge aclk);
		ee_go <= 1'h0;
		repeat (4) @(posedge aclk);
		cmd(32'h3);
		rd(`FSPC_OFS_CTRL);
		chk(status.busy, 32'h0);
		chk(flash_op_page_buf[0], 32'h0);
		repeat (40) @(posedge aclk);
		cmd(32'h1);
		repeat (2) @(posedge aclk);
		chk(flash_op_page_buf[0], 32'h1);
		wr(`FSPC_OFS_CTRL, 32'h11);
		repeat (2) @(posedge aclk);
		chk(flash_op_page_buf[0], 32'h0);
		$display("test buffer done");
		wrap_up();
	end
endmodule : flash_self_program_controller_bench
`default_nettype wire
